//--- core/eipf_pkg.sv
package eipf_pkg;
  // Number of maskable request sources handled here
  localparam int NUM_REQ = 7;
  // Source indices
  localparam int SRC_A = 0;
  localparam int SRC_B = 1;
  localparam int SRC_C = 2;
  localparam int SRC_D = 3;
  localparam int SRC_E = 4;
  localparam int SRC_F = 5;
  localparam int SRC_G = 6;
  // Interrupt types borrowed from the DMA channels
  localparam logic [7:0] TYPE_DMA_A = 8'h0a;
  localparam logic [7:0] TYPE_DMA_B = 8'h0b;
  // Vector types of the general request lines
  localparam logic [7:0] TYPE_LINE_A = 8'h0c;
  localparam logic [7:0] TYPE_LINE_B = 8'h0d;
  localparam logic [7:0] TYPE_LINE_C = 8'h0e;
  localparam logic [7:0] TYPE_LINE_D = 8'h0f;
  localparam logic [7:0] TYPE_LINE_E = 8'h11;
  // Position of the demodulator level in the general I/O data word
  localparam int GPIO_DEMOD_BIT = 31;
  // Reset values
  localparam logic [NUM_REQ-1:0] PEND_RST = 7'h00;
  localparam logic [7:0] TYPE_RST = 8'h00;
  // Acknowledge states
  typedef enum logic [1:0] {
    EIPF_IDLE  = 2'b00,
    EIPF_OFFER = 2'b01,
    EIPF_FETCH = 2'b11
  } eipf_state_t;
endpackage : eipf_pkg

//--- core/eipf_line.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// One request line: sync, edge or level detect, pending flag
module eipf_line (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic req_in,
  input  wire logic level_mode,
  input  wire logic fall_edge,
  input  wire logic clear,
  output var  logic pending,
  output var  logic sync_level
);
  logic s1_reg, s1_next;
  logic s2_reg, s2_next;
  logic s3_reg, s3_next;
  logic pend_reg, pend_next;
  logic event_hit;

  // Two flops resynchronise; the third only feeds the edge detector
  always_comb begin
    s1_next   = req_in;
    s2_next   = s1_reg;
    s3_next   = s2_reg;
    event_hit = fall_edge ? (s3_reg & ~s2_reg) : (s2_reg & ~s3_reg);
    // Set wins over clear so an edge on the ack cycle is kept
    if (level_mode) begin
      pend_next = s2_reg;
    end else if (event_hit) begin
      pend_next = 1'b1;
    end else if (clear) begin
      pend_next = 1'b0;
    end else begin
      pend_next = pend_reg;
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      s1_reg   <= s1_next;
      s2_reg   <= s2_next;
      s3_reg   <= s3_next;
      pend_reg <= pend_next;
    end
  end

  assign pending    = pend_reg;
  assign sync_level = s2_reg;
endmodule : eipf_line
`default_nettype wire

//--- core/eipf_top.sv
`timescale 1ns/1ns
`default_nettype none
module eipf_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  // Request pins
  input  wire logic        ext_req_line_a,
  input  wire logic        ext_req_line_b,
  input  wire logic        ext_req_line_c_i,
  output var  logic        ext_req_line_c_o,
  output var  logic        ext_req_line_c_oe,
  input  wire logic        ext_req_line_d_i,
  output var  logic        ext_req_line_d_o,
  output var  logic        ext_req_line_d_oe,
  input  wire logic        ext_req_line_e,
  input  wire logic        shared_req_line_f,
  input  wire logic        shared_req_line_g,
  input  wire logic        timer_input_a,
  input  wire logic        timer_input_b,
  // Configuration
  input  wire logic [4:0]  level_mode,
  input  wire logic [6:0]  mask,
  input  wire logic        cascade_a_en,
  input  wire logic        cascade_b_en,
  input  wire logic        slave_mode,
  input  wire logic        demod_en,
  input  wire logic        timer_a_is_gpio,
  input  wire logic        timer_b_is_gpio,
  input  wire logic        line_e_is_gpio,
  input  wire logic        dma_a_ext_sync,
  input  wire logic        dma_b_ext_sync,
  // Slave mode pins and type bus
  input  wire logic        slave_select,
  output var  logic        slave_irq,
  input  wire logic [7:0]  ad_type_in,
  // Core side
  output var  logic        core_req,
  output var  logic [7:0]  core_type,
  input  wire logic        core_ack,
  output var  logic        slave_irq_req,
  // Routed outputs
  output var  logic        timer_in_a_int,
  output var  logic        timer_in_b_int,
  output var  logic        dma_req_a_sync,
  output var  logic        dma_req_b_sync,
  output var  logic        gpio_bit_thirty_one,
  input  wire logic        dma_request_ch_a,
  input  wire logic        dma_request_ch_b,
  input  wire logic        slave_irq_set
);
  // ========================================================
  // Input muxing
  logic [6:0] raw_req;
  logic [6:0] pend;
  logic [6:0] sync_lvl;
  logic [6:0] clr;
  logic [6:0] lvl_sel;
  logic [6:0] fall_sel;
  logic [6:0] enable;
  logic       casc_a;
  logic       casc_b;

  assign casc_a = cascade_a_en & ~slave_mode;
  assign casc_b = cascade_b_en & ~slave_mode;

  // Demodulator shares the line c pin; line e takes its falling edge
  always_comb begin
    raw_req = {shared_req_line_g, shared_req_line_f, ext_req_line_e, ext_req_line_d_i,
               ext_req_line_c_i, ext_req_line_b, ext_req_line_a};
    lvl_sel  = {2'b00, level_mode};
    fall_sel = 7'h00;
    if (demod_en) begin
      raw_req[eipf_pkg::SRC_E] = ext_req_line_c_i;
      lvl_sel[eipf_pkg::SRC_E] = 1'b0;
      lvl_sel[eipf_pkg::SRC_C] = 1'b0;
      fall_sel[eipf_pkg::SRC_E] = 1'b1;
    end
    if (casc_a) begin
      raw_req[eipf_pkg::SRC_C] = 1'b0;
    end
    // Line d pin is an output in cascade b and slave mode, never its own request
    if (casc_b || slave_mode) begin
      raw_req[eipf_pkg::SRC_D] = 1'b0;
    end
  end

  // Shared lines serve as interrupts only without DMA sync
  always_comb begin
    enable = 7'h7f;
    enable[eipf_pkg::SRC_F] = ~dma_a_ext_sync;
    enable[eipf_pkg::SRC_G] = ~dma_b_ext_sync;
    enable[eipf_pkg::SRC_B] = ~slave_mode;                  // Pin acts as select
  end

  // ========================================================
  // Per-line recognisers
  genvar gi;
  generate
    for (gi = 0; gi < eipf_pkg::NUM_REQ; gi++) begin : g_line
      eipf_line u_line (
        .clk        (clk),
        .resetn     (resetn),
        .req_in     (raw_req[gi] & enable[gi]),
        .level_mode (lvl_sel[gi]),
        .fall_edge  (fall_sel[gi]),
        .clear      (clr[gi]),
        .pending    (pend[gi]),
        .sync_level (sync_lvl[gi])
      );
    end
  endgenerate

  // ========================================================
  // Priority select and acknowledge sequencing
  eipf_pkg::eipf_state_t state_reg, state_next;
  logic [2:0] src_reg, src_next;
  logic [7:0] type_reg, type_next;
  logic       ack_a_reg, ack_a_next;
  logic       ack_b_reg, ack_b_next;
  logic [6:0] live;
  logic [2:0] win;
  logic       any;
  logic [7:0] win_type;

  assign live = pend & ~mask;

  // Lowest index wins
  always_comb begin
    win = 3'd0;
    any = 1'b0;
    for (int i = eipf_pkg::NUM_REQ - 1; i >= 0; i--) begin
      if (live[i]) begin
        win = 3'(i);
        any = 1'b1;
      end
    end
    unique case (win)
      3'd0:    win_type = eipf_pkg::TYPE_LINE_A;
      3'd1:    win_type = eipf_pkg::TYPE_LINE_B;
      3'd2:    win_type = eipf_pkg::TYPE_LINE_C;
      3'd3:    win_type = eipf_pkg::TYPE_LINE_D;
      3'd4:    win_type = eipf_pkg::TYPE_LINE_E;
      3'd5:    win_type = eipf_pkg::TYPE_DMA_A;
      3'd6:    win_type = eipf_pkg::TYPE_DMA_B;
      default: win_type = eipf_pkg::TYPE_RST;
    endcase
  end

  // Cascaded and slave sources wait for an external type before offering
  always_comb begin
    state_next = state_reg;
    src_next   = src_reg;
    type_next  = type_reg;
    ack_a_next = 1'b0;
    ack_b_next = 1'b0;
    clr        = 7'h00;
    unique case (state_reg)
      eipf_pkg::EIPF_IDLE: begin
        if (any) begin
          src_next  = win;
          type_next = win_type;
          if ((win == 3'd0 && (casc_a || slave_mode)) || (win == 3'd1 && casc_b)) begin
            state_next = eipf_pkg::EIPF_FETCH;
          end else begin
            state_next = eipf_pkg::EIPF_OFFER;
          end
        end
      end
      eipf_pkg::EIPF_FETCH: begin
        ack_a_next = (src_reg == 3'd0) & casc_a;
        ack_b_next = (src_reg == 3'd1) & casc_b;
        // Type is latched from the bus: cascade peer or master select
        if ((slave_mode && slave_select) || (!slave_mode && (ack_a_reg || ack_b_reg))) begin
          type_next  = ad_type_in;
          state_next = eipf_pkg::EIPF_OFFER;
        end else if (!slave_mode && !ack_a_next && !ack_b_next) begin
          // Mode left while waiting: offer the line's own type rather than hang
          state_next = eipf_pkg::EIPF_OFFER;
        end
      end
      eipf_pkg::EIPF_OFFER: begin
        if (core_ack) begin
          clr[src_reg] = 1'b1;
          state_next   = eipf_pkg::EIPF_IDLE;
        end
      end
      default: state_next = eipf_pkg::EIPF_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= eipf_pkg::EIPF_IDLE;
      src_reg   <= 3'd0;
      type_reg  <= eipf_pkg::TYPE_RST;
      ack_a_reg <= 1'b0;
      ack_b_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      src_reg   <= src_next;
      type_reg  <= type_next;
      ack_a_reg <= ack_a_next;
      ack_b_reg <= ack_b_next;
    end
  end

  // ========================================================
  // Outputs
  logic slave_irq_reg_q;
  logic dma_a_s1_reg, sync_dma_a_reg, dma_b_s1_reg, sync_dma_b_reg;
  assign core_req  = (state_reg == eipf_pkg::EIPF_OFFER);
  assign core_type = type_reg;
  // Line c is driven only as a cascade acknowledge; line d also carries the slave request in slave mode
  assign ext_req_line_c_o  = ack_a_reg;
  assign ext_req_line_c_oe = casc_a;
  assign ext_req_line_d_o  = slave_mode ? slave_irq_reg_q : ack_b_reg;
  assign ext_req_line_d_oe = casc_b | slave_mode;
  assign slave_irq_reg_q = slave_irq_set & slave_mode;
  assign slave_irq       = slave_irq_reg_q;
  assign slave_irq_req   = slave_irq_reg_q;
  // Timer input a follows the demodulator and b its inverse when it is enabled, else the timer pins unless they are GPIO
  assign timer_in_a_int = demod_en ? ext_req_line_c_i : (timer_a_is_gpio ? 1'b0 : timer_input_a);
  assign timer_in_b_int = demod_en ? ~ext_req_line_c_i : (timer_b_is_gpio ? 1'b0 : timer_input_b);
  assign gpio_bit_thirty_one = ext_req_line_c_i;
  assign dma_req_a_sync = sync_dma_a_reg;
  assign dma_req_b_sync = sync_dma_b_reg;
  // Level requests are synchronised but never latched
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dma_a_s1_reg   <= 1'b0;
      sync_dma_a_reg <= 1'b0;
      dma_b_s1_reg   <= 1'b0;
      sync_dma_b_reg <= 1'b0;
    end else begin
      dma_a_s1_reg   <= dma_request_ch_a;
      sync_dma_a_reg <= dma_a_s1_reg;
      dma_b_s1_reg   <= dma_request_ch_b;
      sync_dma_b_reg <= dma_b_s1_reg;
    end
  end
endmodule : eipf_top
`default_nettype wire

//--- testbench/eipf_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ====================
// Port checks of the request front end
module eipf_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ext_req_line_c_i,
  input wire logic       ext_req_line_c_oe,
  input wire logic       ext_req_line_d_oe,
  input wire logic       cascade_a_en,
  input wire logic       cascade_b_en,
  input wire logic       slave_mode,
  input wire logic       demod_en,
  input wire logic       timer_in_a_int,
  input wire logic       timer_in_b_int,
  input wire logic       gpio_bit_thirty_one,
  input wire logic       dma_request_ch_a,
  input wire logic       dma_request_ch_b,
  input wire logic       dma_req_a_sync,
  input wire logic       dma_req_b_sync,
  input wire logic       slave_irq,
  input wire logic       slave_irq_req,
  input wire logic       slave_irq_set,
  input wire logic       core_req,
  input wire logic       core_ack,
  input wire logic [4:0] level_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Pin direction follows the configuration in the same cycle; no slack allowed
  property p_oe_c; ext_req_line_c_oe == (cascade_a_en && !slave_mode); endproperty
  a_oe_c: assert property (p_oe_c) else $error("line c enable wrong");
  property p_oe_d; ext_req_line_d_oe == (cascade_b_en || slave_mode); endproperty
  a_oe_d: assert property (p_oe_d) else $error("line d enable wrong");
  // Demodulator routing and the mirror bit are combinational
  property p_route; demod_en |-> timer_in_a_int == ext_req_line_c_i && timer_in_b_int == !ext_req_line_c_i; endproperty
  a_route: assert property (p_route) else $error("timer routing wrong");
  property p_gpio; gpio_bit_thirty_one == ext_req_line_c_i; endproperty
  a_gpio: assert property (p_gpio) else $error("mirror bit wrong");
  // Two-stage sync; guarded so values from inside reset are not compared
  property p_dma; $past(resetn) && $past(resetn, 2) |-> dma_req_a_sync == $past(dma_request_ch_a, 2)
    && dma_req_b_sync == $past(dma_request_ch_b, 2); endproperty
  a_dma: assert property (p_dma) else $error("dma sync wrong");
  property p_irq; slave_irq == (slave_mode && slave_irq_set) && slave_irq_req == slave_irq; endproperty
  a_irq: assert property (p_irq) else $error("slave request wrong");
  // Offer stands until the core answers, then drops within two edges
  property p_hold; core_req && !core_ack |=> core_req; endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_drop; core_req && core_ack && level_mode == 5'h00 |=> ##[0:1] !core_req; endproperty
  a_drop: assert property (p_drop) else $error("request not cleared");
endmodule : eipf_checker
bind eipf_top eipf_checker i_eipf_checker (.clk, .resetn, .ext_req_line_c_i, .ext_req_line_c_oe,
  .ext_req_line_d_oe, .cascade_a_en, .cascade_b_en, .slave_mode, .demod_en, .timer_in_a_int, .timer_in_b_int,
  .gpio_bit_thirty_one, .dma_request_ch_a, .dma_request_ch_b, .dma_req_a_sync, .dma_req_b_sync,
  .slave_irq, .slave_irq_req, .slave_irq_set, .core_req, .core_ack, .level_mode);
`default_nettype wire

//--- testbench/eipf_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ====================
// Cascaded peripherals and external master on the type bus
module eipf_partner (
  input  wire logic       clk,
  input  wire logic       ack_a,
  input  wire logic       ack_b,
  input  wire logic       line_a,
  input  wire logic       slave_en,
  output var  logic [7:0] ad_type,
  output var  logic       select
);
  logic       seen_reg;
  logic [7:0] bus_reg;
  wire        go = seen_reg && slave_en && line_a;
  initial begin
    bus_reg = 8'h00;
    select = 1'b0;
    seen_reg = 1'b0;
  end
  // A cascaded peer answers while its acknowledge stands, so the type is there when sampled
  assign ad_type = ack_a ? 8'h71 : (ack_b ? 8'h72 : bus_reg);
  // Select only after line a was seen; an idle bus toggles so no stale value passes
  always @(posedge clk) begin
    seen_reg <= slave_en && line_a;
    select <= go;
    if (go) bus_reg <= 8'h5a;
    else bus_reg <= ~bus_reg;
  end
endmodule : eipf_partner
`default_nettype wire

//--- testbench/eipf_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
// ====================
// Bench top: drives request pins and plays the core
module eipf_top_tb;
  logic clk, resetn, core_ack, timer_input_a, timer_input_b, cascade_a_en, cascade_b_en, slave_mode, demod_en;
  logic timer_a_is_gpio, timer_b_is_gpio, line_e_is_gpio, dma_a_ext_sync, dma_b_ext_sync, slave_select;
  logic dma_request_ch_a, dma_request_ch_b, slave_irq_set, slave_irq, slave_irq_req, core_req, c_o, c_oe;
  logic d_o, d_oe, timer_in_a_int, timer_in_b_int, dma_req_a_sync, dma_req_b_sync, gpio_bit_thirty_one;
  logic [4:0]  level_mode;
  logic [6:0]  mask, req;
  logic [7:0]  ad_type_in, core_type;
  logic [31:0] seed;
  int          miscompares, total_checks, cyc, n;
  // Pin levels resolved from both drivers
  wire c_pin = c_oe ? c_o : req[2];
  wire d_pin = d_oe ? d_o : req[3];
  eipf_top i_eipf_top (.clk, .resetn, .ext_req_line_a(req[0]), .ext_req_line_b(req[1]), .ext_req_line_c_i(c_pin),
    .ext_req_line_c_o(c_o), .ext_req_line_c_oe(c_oe), .ext_req_line_d_i(d_pin), .ext_req_line_d_o(d_o),
    .ext_req_line_d_oe(d_oe), .ext_req_line_e(req[4]), .shared_req_line_f(req[5]), .shared_req_line_g(req[6]),
    .timer_input_a, .timer_input_b, .level_mode, .mask, .cascade_a_en, .cascade_b_en, .slave_mode, .demod_en,
    .timer_a_is_gpio, .timer_b_is_gpio, .line_e_is_gpio, .dma_a_ext_sync, .dma_b_ext_sync, .slave_select,
    .slave_irq, .ad_type_in, .core_req, .core_type, .core_ack, .slave_irq_req, .timer_in_a_int, .timer_in_b_int,
    .dma_req_a_sync, .dma_req_b_sync, .gpio_bit_thirty_one, .dma_request_ch_a, .dma_request_ch_b, .slave_irq_set);
  eipf_partner i_eipf_partner (.clk, .ack_a(c_o && c_oe), .ack_b(d_o && d_oe), .line_a(req[0]),
    .slave_en(slave_mode), .ad_type(ad_type_in), .select(slave_select));
  // Clock and a hang limit well above the expected run
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : rnd
  function automatic logic [7:0] exp_type(int i);
    logic [7:0] t [7] = '{eipf_pkg::TYPE_LINE_A, eipf_pkg::TYPE_LINE_B, eipf_pkg::TYPE_LINE_C,
      eipf_pkg::TYPE_LINE_D, eipf_pkg::TYPE_LINE_E, eipf_pkg::TYPE_DMA_A, eipf_pkg::TYPE_DMA_B};
    return t[i];
  endfunction : exp_type
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic ack();
    core_ack = 1'b1;
    @(negedge clk) core_ack = 1'b0;
  endtask : ack
  task automatic wait_req(int lim);
    n = 0;
    while (!core_req && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_req
  // One request: latency, type, refusal and level re-trigger; the pin is held past the ack
  task automatic run(int i, logic m, logic lvl, logic ds);
    logic e;
    e = !m && !(ds && i > 4);
    mask = m ? 7'h01 << i : 7'h00;
    level_mode = lvl ? 5'h1f : 5'h00;
    {dma_a_ext_sync, dma_b_ext_sync} = {ds, ds};
    @(negedge clk) req[i] = 1'b1;
    wait_req(8);
    `CHK(core_req, e)
    if (e) begin
      `CHK(n, 4)
      `CHK(core_type, exp_type(i))
      ack();
      repeat (6) @(negedge clk);
      `CHK(core_req, lvl && i < 5)
    end
    req[i] = 1'b0;
    mask = 7'h00; // Serve what the mask held back so no stale pending leaks into the next run
    repeat (6) @(negedge clk);
    if (core_req) ack();
    repeat (3) @(negedge clk);
  endtask : run
  // Main sequence: corners, random requests, routing, demodulation, slave, cascade
  initial begin
    {req, timer_input_a, timer_input_b, cascade_a_en, cascade_b_en, slave_mode, demod_en, timer_a_is_gpio,
      timer_b_is_gpio, line_e_is_gpio, dma_a_ext_sync, dma_b_ext_sync, core_ack, dma_request_ch_a,
      dma_request_ch_b, slave_irq_set, level_mode, mask, resetn} = '0;
    seed = 32'h000024a4;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 7; i++) begin
      run(i, 1'b0, 1'b0, 1'b0);
      run(i, 1'b1, 1'b0, 1'b0);
      run(i, 1'b0, 1'b1, i > 4);
    end
    repeat (20) begin
      seed = rnd(seed);
      run(int'(seed % 7), seed[4], seed[5], seed[6]);
    end
    mask = 7'h7f;
    repeat (60) begin
      seed = rnd(seed);
      @(negedge clk) {timer_input_a, timer_input_b, req[4:2], demod_en, slave_mode, slave_irq_set,
        dma_request_ch_a, dma_request_ch_b, timer_a_is_gpio, timer_b_is_gpio, line_e_is_gpio} = seed[12:0];
    end
    {req, demod_en, slave_mode, resetn} = '0;
    repeat (2) @(negedge clk) resetn = 1'b1;
    // Only internal line e is open; the pins it replaces must be ignored
    {req[2], demod_en, mask} = {2'b11, 7'h6f};
    @(negedge clk) req[4] = 1'b1;
    repeat (8) @(negedge clk);
    `CHK(core_req, 1'b0)
    req[2] = 1'b0;
    wait_req(8);
    `CHK(core_type, eipf_pkg::TYPE_LINE_E)
    ack();
    // Reset again so line c, left pending behind its mask, cannot jump ahead of the slave request
    resetn = 1'b0;
    @(negedge clk) {req, demod_en, mask, slave_mode, level_mode, resetn} = {7'h01, 1'b0, 7'h00, 1'b1, 5'h00, 1'b1};
    wait_req(12);
    repeat (4) @(negedge clk);
    `CHK(core_type, 8'h5a)
    ack();
    {req, slave_mode} = '0;
    repeat (6) @(negedge clk);
    if (core_req) ack();
    // Cascade on line a then line b: the paired pin must pulse as an acknowledge
    for (int k = 0; k < 2; k++) begin
      {cascade_b_en, cascade_a_en} = 2'b01 << k;
      req[k] = 1'b1;
      n = 0;
      repeat (30) @(negedge clk) begin
        if (k == 0 ? c_o && c_oe : d_o && d_oe) n++;
        if (core_req) begin
          `CHK(core_type, k == 0 ? 8'h71 : 8'h72)
          ack();
        end
      end
      `CHK(n > 0, 1'b1)
      {req, cascade_a_en, cascade_b_en} = '0;
      repeat (6) @(negedge clk);
    end
    report_and_stop();
  end
endmodule : eipf_top_tb
`default_nettype wire
